//--- rtl/flash_prog_pkg.sv
// Constants and types for the on-board flash programming control block.
// Assumes a 24-bit byte address space and an 8-bit serial byte stream.
package flash_prog_pkg;
   localparam int unsigned ADDR_W = 24;
   localparam int unsigned NUM_BLOCKS = 8;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam logic [23:0] CTRL_PROG_START = 24'hFF_F520;
   localparam logic [23:0] OVERLAP_RAM_BASE = 24'hFF_F000;
   localparam logic [23:0] BOOT_AREA_BASE = 24'hFF_E000;
   localparam logic [15:0] BOOT_ROUTINE_LEN = 16'h0040;
   localparam logic [23:0] OVL_WIN_SIZE = 24'h00_0400;
   localparam int unsigned ID_LEN = 8;
   localparam logic [63:0] ID_CODE = 64'h0123_4567_89AB_CDEF;  // Value is arbitrary.
   localparam logic [2:0] RST_MD = 3'h0;
   localparam logic [15:0] RST_CNT = 16'h0000;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000, ST_COPY = 3'b001, ST_ERASE = 3'b011, ST_LOAD = 3'b010,
      ST_CHECK = 3'b110, ST_RUN = 3'b111, ST_HALT = 3'b101
   } boot_st_t;
   typedef enum logic [1:0] {
      OP_USER = 2'b00, OP_BOOT = 2'b01, OP_UPROG = 2'b11, OP_NONE = 2'b10
   } op_mode_t;
endpackage

//--- rtl/flash_prog_if.sv
// Interface carrying flash block decode between the control and its decoder.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
`default_nettype none
interface flash_prog_if;
   logic [23:0] addr;
   logic [7:0]  blk_sel;
   logic        in_flash;
   modport ctrl (output addr, input blk_sel, input in_flash);
   modport dec  (input addr, output blk_sel, output in_flash);
endinterface
`default_nettype wire

//--- rtl/flash_block_decode.sv
// Decoder from flash address to one of eight erase blocks.
// Assumes the flash array starts at address zero and spans 128 kbytes.
`timescale 1ns/1ns
`default_nettype none
module flash_block_decode (
   flash_prog_if.dec bus
);
   always_comb begin
      bus.blk_sel = 8'h00;
      bus.in_flash = (bus.addr[23:17] == 7'h00);
      // Four 1k blocks, one 28k block, three 32k blocks.
      if (bus.in_flash) begin
         if (bus.addr[16:15] != 2'b00)
            bus.blk_sel[4 + bus.addr[16:15]] = 1'b1;
         else if (bus.addr[14:12] != 3'h0)
            bus.blk_sel[4] = 1'b1;
         else
            bus.blk_sel[bus.addr[11:10]] = 1'b1;
      end
   end
endmodule
`default_nettype wire

//--- rtl/flash_onboard_program_modes.sv
// Mode decode, boot loader sequencing, erase gating and overlap RAM steering.
// Assumes pins are asynchronous and serial bytes arrive as one-cycle strobes.
//
// Contract
// - Boot mode erases whole flash to ones.
// - Outside boot, erase whole blocks only.
// - Eight blocks: 3x32k, 1x28k, 4x1k.
// - Programming pins plus reset permit program/erase.
// - Decode write-enable and mode pins into modes.
// - No programming modes in mode six.
// - Mode select bits mirror pins, top inverted.
// - Boot transfer over asynchronous serial channel one.
// - Loader stores received bytes sequentially in RAM.
// - ID match branches to fixed start address.
// - Boot entry copies erase routine to boot area.
// - Emulation reads of chosen block return RAM.
// - Clearing select bit restores real flash access.
// - User mode allows reads, blocks program/erase.
// - Select bit set protects all blocks.
// - Area bits pick one of four 1k windows.
`timescale 1ns/1ns
`default_nettype none
module flash_onboard_program_modes (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   // Mode pins
   input  wire logic        flash_write_enable_pin,
   input  wire logic        mode_pin_2,
   input  wire logic        mode_pin_1,
   input  wire logic        mode_pin_0,
   // Serial channel received bytes
   input  wire logic        serial_channel_async,
   input  wire logic        serial_rx_valid,
   input  wire logic [7:0]  serial_rx_data,
   input  wire logic [15:0] prog_len,
   // Overlap RAM control
   input  wire logic        overlap_ram_select,
   input  wire logic        overlap_area_bit_hi,
   input  wire logic        overlap_area_bit_lo,
   // Software erase request and CPU access address
   input  wire logic        erase_req,
   input  wire logic [7:0]  erase_blocks,
   input  wire logic        prog_req,
   input  wire logic [23:0] cpu_addr,
   // Mode status
   output logic [2:0]       mode_control_register,
   output logic [1:0]       op_mode,
   output logic             prog_enable,
   // Boot loader RAM writes and branch
   output logic             ram_we,
   output logic [23:0]      ram_addr,
   output logic [7:0]       ram_wdata,
   output logic             branch,
   output logic [23:0]      branch_addr,
   output logic             boot_fail,
   // Flash operations
   output logic             flash_erase_all,
   output logic [7:0]       flash_erase_blk,
   output logic             flash_prog_ok,
   output logic             read_from_ram,
   output logic [23:0]      read_addr
);
   flash_prog_if fif ();
   flash_block_decode u_dec (.bus(fif));

   logic [3:0] pin_s1_r, pin_s2_r;
   // The latch must wait until the second stage holds real pin levels.
   // Latching on the first edge would take the reset value and select user mode.
   logic [1:0] sync_vld_r;
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         pin_s1_r <= 4'h0;
         pin_s2_r <= 4'h0;
         sync_vld_r <= 2'b00;
      end else begin
         pin_s1_r <= {flash_write_enable_pin, mode_pin_2, mode_pin_1, mode_pin_0};
         pin_s2_r <= pin_s1_r;
         sync_vld_r <= {sync_vld_r[0], 1'b1};
      end
   end

   // Mode is latched once after reset release, as the pins must not change afterwards.
   logic latched_r;
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         latched_r <= 1'b0;
         op_mode <= flash_prog_pkg::OP_NONE;
         mode_control_register <= flash_prog_pkg::RST_MD;
         prog_enable <= 1'b0;
      end else if (!latched_r && sync_vld_r[1]) begin
         latched_r <= 1'b1;
         mode_control_register <= {~pin_s2_r[2], pin_s2_r[1:0]};
         if (pin_s2_r[0] && pin_s2_r[3]) begin
            // Mode six has low mode pin 0, so it never reaches here.
            op_mode <= pin_s2_r[2] ? flash_prog_pkg::OP_UPROG
                                   : flash_prog_pkg::OP_BOOT;
            prog_enable <= 1'b1;
         end else begin
            op_mode <= flash_prog_pkg::OP_USER;
            prog_enable <= 1'b0;
         end
      end
   end

   flash_prog_pkg::boot_st_t st_r;
   logic [15:0] cnt_r;
   logic [63:0] id_r;
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         st_r <= flash_prog_pkg::ST_IDLE;
         cnt_r <= flash_prog_pkg::RST_CNT;
         id_r <= 64'h0000_0000_0000_0000;
         ram_we <= 1'b0;
         ram_addr <= 24'h00_0000;
         ram_wdata <= 8'h00;
         branch <= 1'b0;
         branch_addr <= 24'h00_0000;
         boot_fail <= 1'b0;
         flash_erase_all <= 1'b0;
      end else begin
         ram_we <= 1'b0;
         flash_erase_all <= 1'b0;
         case (st_r)
            flash_prog_pkg::ST_IDLE: begin
               if (latched_r && op_mode == flash_prog_pkg::OP_BOOT) begin
                  st_r <= flash_prog_pkg::ST_COPY;
                  cnt_r <= flash_prog_pkg::RST_CNT;
               end
            end
            flash_prog_pkg::ST_COPY: begin
               // Erase routine image goes to its own area, away from the download.
               ram_we <= 1'b1;
               ram_addr <= flash_prog_pkg::BOOT_AREA_BASE + {8'h00, cnt_r};
               ram_wdata <= cnt_r[7:0];
               cnt_r <= cnt_r + 16'h0001;
               if (cnt_r == flash_prog_pkg::BOOT_ROUTINE_LEN - 16'h0001) begin
                  st_r <= flash_prog_pkg::ST_ERASE;
               end
            end
            flash_prog_pkg::ST_ERASE: begin
               flash_erase_all <= 1'b1;
               cnt_r <= flash_prog_pkg::RST_CNT;
               st_r <= flash_prog_pkg::ST_LOAD;
            end
            flash_prog_pkg::ST_LOAD: begin
               if (serial_rx_valid && serial_channel_async) begin
                  ram_we <= 1'b1;
                  ram_addr <= flash_prog_pkg::CTRL_PROG_START + {8'h00, cnt_r};
                  ram_wdata <= serial_rx_data;
                  // The first bytes double as the ID word, the oldest byte ending on top.
                  if (cnt_r < 16'(flash_prog_pkg::ID_LEN)) begin
                     id_r <= {id_r[55:0], serial_rx_data};
                  end
                  cnt_r <= cnt_r + 16'h0001;
                  if (cnt_r + 16'h0001 >= prog_len) begin
                     st_r <= flash_prog_pkg::ST_CHECK;
                  end
               end
            end
            flash_prog_pkg::ST_CHECK: begin
               if (id_r == flash_prog_pkg::ID_CODE) begin
                  branch <= 1'b1;
                  branch_addr <= flash_prog_pkg::CTRL_PROG_START;
                  st_r <= flash_prog_pkg::ST_RUN;
               end else begin
                  boot_fail <= 1'b1;
                  st_r <= flash_prog_pkg::ST_HALT;
               end
            end
            flash_prog_pkg::ST_RUN: st_r <= flash_prog_pkg::ST_RUN;
            flash_prog_pkg::ST_HALT: st_r <= flash_prog_pkg::ST_HALT;
            default: st_r <= flash_prog_pkg::ST_IDLE;
         endcase
      end
   end

   // Software erase and program gating.
   logic protect;
   assign protect = !prog_enable || overlap_ram_select;
   assign fif.addr = cpu_addr;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         flash_erase_blk <= 8'h00;
         flash_prog_ok <= 1'b0;
      end else begin
         // Only block-wide erase exists; one block at a time is honoured.
         if (erase_req && !protect && $onehot(erase_blocks))
            flash_erase_blk <= erase_blocks;
         else
            flash_erase_blk <= 8'h00;
         flash_prog_ok <= prog_req && !protect && fif.in_flash;
      end
   end

   // Overlap steering for reads.
   // Boot mode never steers, so a download cannot be shadowed by overlap RAM.
   logic [1:0] area;
   logic       hit;
   assign area = {overlap_area_bit_hi, overlap_area_bit_lo};
   assign hit = overlap_ram_select && prog_enable == (op_mode == flash_prog_pkg::OP_UPROG)
                && fif.blk_sel[area] && op_mode != flash_prog_pkg::OP_BOOT;
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         read_from_ram <= 1'b0;
         read_addr <= 24'h00_0000;
      end else if (hit) begin
         read_from_ram <= 1'b1;
         read_addr <= flash_prog_pkg::OVERLAP_RAM_BASE + {14'h0000, cpu_addr[9:0]};
      end else begin
         read_from_ram <= 1'b0;
         read_addr <= cpu_addr;
      end
   end
endmodule
`default_nettype wire

//--- verif/flash_prog_assertions.sv
// Concurrent checks on the top ports of the flash programming control block.
// Assumes mode pins stay put between resets.
`timescale 1ns/1ns
`default_nettype none
module flash_prog_assertions (
   // Clock and reset
   input wire logic        clk_sys,
   input wire logic        rstn,
   // Pins and controls
   input wire logic        mode_pin_2,
   input wire logic        mode_pin_1,
   input wire logic        mode_pin_0,
   input wire logic        overlap_ram_select,
   input wire logic        overlap_area_bit_hi,
   input wire logic        overlap_area_bit_lo,
   input wire logic        erase_req,
   input wire logic [7:0]  erase_blocks,
   input wire logic [23:0] cpu_addr,
   // Outputs watched
   input wire logic [2:0]  mode_control_register,
   input wire logic [1:0]  op_mode,
   input wire logic        prog_enable,
   input wire logic        branch,
   input wire logic [23:0] branch_addr,
   input wire logic        boot_fail,
   input wire logic        flash_erase_all,
   input wire logic [7:0]  flash_erase_blk,
   input wire logic        read_from_ram,
   input wire logic [23:0] read_addr
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   erase_take_a: assert property (erase_req && prog_enable && !overlap_ram_select &&
      $onehot(erase_blocks) |=> flash_erase_blk == $past(erase_blocks)) else $error("erase lost");
   erase_refuse_a: assert property (erase_req && (!prog_enable || overlap_ram_select ||
      !$onehot(erase_blocks)) |=> flash_erase_blk == 8'h00) else $error("erase not refused");
   erase_onehot_a: assert property (flash_erase_blk != 8'h00 |-> $onehot(flash_erase_blk))
      else $error("erase of several blocks");
   erase_all_a: assert property (flash_erase_all |-> op_mode == flash_prog_pkg::OP_BOOT &&
      !branch) else $error("whole erase outside loader");
   prog_mode_a: assert property (prog_enable |-> op_mode inside {flash_prog_pkg::OP_BOOT,
      flash_prog_pkg::OP_UPROG}) else $error("programming enabled in wrong mode");
   mode_bits_a: assert property (op_mode == flash_prog_pkg::OP_BOOT |->
      mode_control_register == {~mode_pin_2, mode_pin_1, mode_pin_0}) else $error("mode bits");
   ram_read_a: assert property (op_mode inside {flash_prog_pkg::OP_USER, flash_prog_pkg::OP_UPROG}
      && overlap_ram_select && cpu_addr[23:12] == 12'h000
      && cpu_addr[11:10] == {overlap_area_bit_hi, overlap_area_bit_lo} |=> read_from_ram &&
      read_addr == (flash_prog_pkg::OVERLAP_RAM_BASE | {14'h0, $past(cpu_addr[9:0])}))
      else $error("overlap read not steered");
   no_overlap_a: assert property (!overlap_ram_select || op_mode == flash_prog_pkg::OP_BOOT
      |=> !read_from_ram) else $error("overlap read without select");
   branch_ok_a: assert property (branch |-> branch_addr == flash_prog_pkg::CTRL_PROG_START
      && !boot_fail) else $error("branch target");
   branch_hold_a: assert property (branch |=> branch) else $error("branch dropped");
   cover property (branch);
   cover property (boot_fail);
   cover property (read_from_ram);
endmodule
bind flash_onboard_program_modes flash_prog_assertions chk (.clk_sys, .rstn, .mode_pin_2,
   .mode_pin_1, .mode_pin_0, .overlap_ram_select, .overlap_area_bit_hi, .overlap_area_bit_lo,
   .erase_req, .erase_blocks, .cpu_addr, .mode_control_register, .op_mode, .prog_enable,
   .branch, .branch_addr, .boot_fail, .flash_erase_all, .flash_erase_blk, .read_from_ram,
   .read_addr);
`default_nettype wire

//--- verif/host_serial_model.sv
// Host side of the boot download: sends ID bytes, then program bytes.
// Assumes the bench raises go only once the loader has erased the flash.
`timescale 1ns/1ns
`default_nettype none
module host_serial_model (
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rstn,
   // Bench control
   input  wire logic       go,
   input  wire logic       bad_id,
   // Received byte stream
   output var  logic       serial_channel_async,
   output var  logic       serial_rx_valid,
   output var  logic [7:0] serial_rx_data
);
   int n;
   // The data lines invert every cycle while valid is low, so stale reads show up.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         n <= 0;
         serial_rx_valid <= 1'b0;
         serial_rx_data <= 8'h00;
         serial_channel_async <= 1'b1;
      end else if (go && n < 24 && !n[0]) begin
         n <= n + 1;
         serial_rx_valid <= 1'b1;
         serial_rx_data <= (n < 16) ? flash_prog_pkg::ID_CODE[63-4*n -: 8] ^ {7'h0, bad_id
            && n == 14} : 8'hA0 + 8'(n / 2);
      end else begin
         n <= (go && n < 24) ? n + 1 : n;
         serial_rx_valid <= 1'b0;
         serial_rx_data <= ~serial_rx_data;
      end
   end
endmodule
`default_nettype wire

//--- verif/test_flash_onboard_program_modes.sv
// Bench for mode decode, boot download, erase gating and overlap reads.
// Assumes the host model sends twelve bytes once go rises.
`timescale 1ns/1ns
`default_nettype none
module test_flash_onboard_program_modes;
   logic        clk_sys, rstn, flash_write_enable_pin, mode_pin_2, mode_pin_1, mode_pin_0;
   logic        serial_channel_async, serial_rx_valid, prog_req, erase_req, go, bad_id;
   logic        overlap_ram_select, overlap_area_bit_hi, overlap_area_bit_lo, ram_we, branch;
   logic        prog_enable, boot_fail, flash_erase_all, flash_prog_ok, read_from_ram;
   logic [7:0]  serial_rx_data, erase_blocks, ram_wdata, flash_erase_blk;
   logic [23:0] cpu_addr, ram_addr, branch_addr, read_addr;
   logic [15:0] prog_len;
   logic [2:0]  mode_control_register;
   logic [1:0]  op_mode;
   int          err_total, total_checks, wcount;
   flash_onboard_program_modes dut (.clk_sys, .rstn, .flash_write_enable_pin, .mode_pin_2,
      .mode_pin_1, .mode_pin_0, .serial_channel_async, .serial_rx_valid, .serial_rx_data,
      .prog_len, .overlap_ram_select, .overlap_area_bit_hi, .overlap_area_bit_lo, .erase_req,
      .erase_blocks, .prog_req, .cpu_addr, .mode_control_register, .op_mode, .prog_enable,
      .ram_we, .ram_addr, .ram_wdata, .branch, .branch_addr, .boot_fail, .flash_erase_all,
      .flash_erase_blk, .flash_prog_ok, .read_from_ram, .read_addr);
   host_serial_model host (.clk_sys, .rstn, .go, .bad_id, .serial_channel_async,
      .serial_rx_valid, .serial_rx_data);
   task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic start(input logic [3:0] pins, input logic bad);
      @(posedge clk_sys);
      rstn <= 1'b0;
      prog_len <= 16'h000C;
      go <= 1'b0;
      bad_id <= bad;
      {flash_write_enable_pin, mode_pin_2, mode_pin_1, mode_pin_0} <= pins;
      repeat (8) @(posedge clk_sys);
      rstn <= 1'b1;
      repeat (4) @(posedge clk_sys);
      #1;
   endtask
   task automatic wait_hi(input bit done);
      int k;
      k = 0;
      while ((done ? branch | boot_fail : flash_erase_all) !== 1'b1) begin
         @(negedge clk_sys);
         k++;
         if (k > 500) begin
            err_total++;
            wrap_up();
         end
      end
   endtask
   task automatic req(input logic e, input logic [7:0] b, input logic [23:0] a, input logic x);
      @(posedge clk_sys);
      {erase_req, prog_req, erase_blocks, cpu_addr} <= {e, !e, b, a};
      @(posedge clk_sys);
      {erase_req, prog_req} <= 2'b00;
      #1;
      check(e ? "erase" : "prog", e ? flash_erase_blk : flash_prog_ok, e ? {8{x}} & b : x);
   endtask
   task automatic rd(input logic s, input logic [23:0] a, input logic r);
      @(posedge clk_sys);
      {overlap_ram_select, cpu_addr} <= {s, a};
      repeat (2) @(posedge clk_sys);
      #1;
      check("ram read", read_from_ram, r);
   endtask
   // Every RAM write of the loader: 64 routine bytes first, then the downloaded bytes.
   always @(negedge clk_sys) begin
      if (rstn !== 1'b1) wcount = 0;
      else if (ram_we === 1'b1) begin
         if (wcount < 64) check("copy", 24'({ram_addr, ram_wdata}
            - flash_prog_pkg::BOOT_AREA_BASE * 256), 24'(wcount * 257));
         else begin
            check("load", ram_addr - flash_prog_pkg::CTRL_PROG_START, 24'(wcount - 64));
            check("load window", 24'(ram_addr - flash_prog_pkg::OVERLAP_RAM_BASE
               >= flash_prog_pkg::OVL_WIN_SIZE), 24'h00_0001);
         end
         if (wcount >= 72) check("load data", ram_wdata, 8'hA0 + 8'(wcount - 64));
         wcount++;
      end
   end
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   initial begin
      {erase_req, prog_req, erase_blocks, cpu_addr, prog_len} <= '0;
      {overlap_ram_select, overlap_area_bit_hi, overlap_area_bit_lo} <= 3'b010;
      {err_total, total_checks} = 0;
      for (int i = 0; i < 2; i++) begin
         start(4'hB, i[0]);
         check("mode", op_mode, flash_prog_pkg::OP_BOOT);
         check("mode bits", mode_control_register, 3'h7);
         wait_hi(1'b0);
         check("erase all", flash_erase_all, 1'b1);
         @(posedge clk_sys);
         go <= 1'b1;
         wait_hi(1'b1);
         #20;
         check("branch", branch, !i[0]);
         check("fail", boot_fail, i[0]);
         check("branch addr", branch_addr, i[0] ? 24'h00_0000 : flash_prog_pkg::CTRL_PROG_START);
         check("writes", 24'(wcount), 24'h00_004C);
      end
      start(4'hD, 1'b0);
      check("uprog", {op_mode, prog_enable}, {flash_prog_pkg::OP_UPROG, 1'b1});
      req(1'b1, 8'h80, 24'h00_0000, 1'b1);
      req(1'b1, 8'h06, 24'h00_0000, 1'b0);
      req(1'b0, 8'h00, 24'h01_FFFF, 1'b1);
      req(1'b0, 8'h00, 24'h02_0000, 1'b0);
      rd(1'b1, 24'h00_0805, 1'b1);
      check("ram addr", read_addr, 24'hFF_F005);
      req(1'b1, 8'h01, 24'h00_0805, 1'b0);
      rd(1'b1, 24'h00_0405, 1'b0);
      rd(1'b0, 24'h00_0805, 1'b0);
      start(4'h7, 1'b0);
      check("user", {op_mode, prog_enable}, {flash_prog_pkg::OP_USER, 1'b0});
      req(1'b1, 8'h01, 24'h00_0000, 1'b0);
      start(4'hE, 1'b0);
      check("mode six", prog_enable, 1'b0);
      req(1'b1, 8'h01, 24'h00_0000, 1'b0);
      wrap_up();
   end
endmodule
`default_nettype wire
